/* File: rtl/msr_status_bank.sv */
/*
  Motion status register bank: error, axis and system status words on APB,
  with the software trap overlay and trap parameter registers.
  Assumes all status sources come from controller logic on clk_sys.
*/
// Local design decisions: the APB register port and the placing of the registers.
//
// Contract
// - Resolver error bit set on tracking fault or disconnect, only with option fitted.
// - Error bit 12 when command minus feedback position exceeds threshold.
// - Error bit 13 when velocity feedback exceeds its trap threshold.
// - Error bit 14 when derived accel/decel exceeds its trap threshold.
// - Error bit 15 when current command stays at limit past timeout.
// - Error bits 16 to 18 set by writing ones to overlay register.
// - Trap 1 stops task 1, trap 2 stops task 2, trap 3 disables amplifier.
// - Error bits 19 and 20 flag run-time errors in tasks 1 and 2.
// - Bit 21 flags calibration range errors while calibration is enabled.
// - Axis bits 4-7 position source, bits 14-17 velocity source.
// - Axis bits 10-13 commutation method, bits 19-20 six-step sub-mode.
// - Axis bits 21 motion present, 22 disable processing, 23 homed since reset.
// - Axis bits 0, 1, 3, 8, 9, 18 report loop and marker settings.
// - System bit 0 follows last absolute or incremental mode command.
// - System bit 1 is kernel sync flag, active only when select is 3.
// - System bits 2 and 3 show tasks 1 and 2 running.
// - System bits 4 and 5 show block mode for tasks 1 and 2.
// - System bits 6 and 7 show a block executing in tasks 1, 2.
// - System bits 8 and 9 set once a hold command is issued.
// - System bit 11 shows 14-bit resolver tracking, only when mode is 4.
// - System bit 12 when recirculation is 1 or 2, bit 13 only for 2.
// - System bits 10, 14, 15: command reference, gear mode, calibration enabled.
`timescale 1ns/10ps
module msr_status_bank (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Motion feedback
  input wire logic signed [31:0] cmdPos,
  input wire logic signed [31:0] fbPos,
  input wire logic signed [31:0] fbVel,
  input wire logic signed [15:0] curCmd,
  input wire logic [15:0] calIndex,
  // Fault sources
  input wire logic resolverFitted,
  input wire logic resolverTrackFault,
  input wire logic resolverDisconnected,
  input wire logic [1:0] runTimeError,
  // Axis configuration
  input wire logic [3:0] posFbSource,
  input wire logic [3:0] velFbSource,
  input wire logic [3:0] commutation,
  input wire logic [1:0] sixStepMode,
  input wire logic [1:0] markerSource,
  input wire logic feedforwardOn,
  input wire logic integDisabled,
  input wire logic curCmdNegated,
  input wire logic holdCurrentHigh,
  input wire logic motionPresent,
  input wire logic disableMaskBusy,
  input wire logic homingStart,
  input wire logic softReset,
  // Task and kernel state
  input wire logic absolute_mode_cmd,
  input wire logic incremental_mode_cmd,
  input wire logic kernelSync,
  input wire logic [1:0] taskRunning,
  input wire logic [1:0] taskBlockMode,
  input wire logic [1:0] taskBlockExec,
  input wire logic hold_task_one_cmd,
  input wire logic hold_task_two_cmd,
  input wire logic [1:0] holdRelease,
  input wire logic posCmdReference,
  input wire logic resolver14Bit,
  input wire logic gearActive,
  // Trap actions
  output logic stopTask1,
  output logic stopTask2,
  output logic ampDisable
);
  msr_trap_if tr ();

  function automatic logic msrHit(input logic [7:0] a, input logic [7:0] off);
    msrHit = (a[7:2] == off[7:2]);
  endfunction

  logic [31:0] posErrThr_reg;
  logic [31:0] velThr_reg;
  logic [31:0] accelThr_reg;
  logic [15:0] curLevel_reg;
  logic [15:0] curTimeout_reg;
  logic [15:0] calSize_reg;
  logic [9:0] config_reg;
  logic [msr_pkg::SW_TRAP_COUNT-1:0] swTrap_reg;
  logic [23:0] errWord_reg;
  logic [23:0] axisWord_reg;
  logic [23:0] sysWord_reg;
  logic [23:0] errWord_next;
  logic [23:0] axisWord_next;
  logic [23:0] sysWord_next;
  logic absMode_reg;
  logic [1:0] hold_reg;
  logic homed_reg;
  logic [7:0] tickCount_reg;
  logic updateTick;
  logic setupPhase;
  logic wrEn;
  logic mapped;
  logic [1:0] kSel;
  logic [3:0] resMode;
  logic [1:0] recirc;

  assign kSel = config_reg[msr_pkg::CFG_KSYNC_LSB +: 2];
  assign resMode = config_reg[msr_pkg::CFG_RESMODE_LSB +: 4];
  assign recirc = config_reg[msr_pkg::CFG_RECIRC_LSB +: 2];

  // Update-cycle divider
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      tickCount_reg <= '0;
    else if (updateTick)
      tickCount_reg <= '0;
    else
      tickCount_reg <= tickCount_reg + 8'h01;
  end
  assign updateTick = (tickCount_reg == 8'(msr_pkg::UPDATE_CYCLES - 1));

  // Trap evaluator hookup
  assign tr.updateTick = updateTick;
  assign tr.cmdPos = cmdPos;
  assign tr.fbPos = fbPos;
  assign tr.fbVel = fbVel;
  assign tr.curCmd = curCmd;
  assign tr.posErrThr = posErrThr_reg;
  assign tr.velThr = velThr_reg;
  assign tr.accelThr = accelThr_reg;
  assign tr.curLevel = curLevel_reg;
  assign tr.curTimeout = curTimeout_reg;
  assign tr.calEnable = config_reg[msr_pkg::CFG_CAL_EN];
  assign tr.calIndex = calIndex;
  assign tr.calSize = calSize_reg;

  msr_trap_eval u_eval (
    .clk_sys(clk_sys),
    .rst(rst),
    .tr(tr.eval)
  );

  // APB decode; zero wait states, so pready is a constant level
  assign setupPhase = psel && !penable;
  assign wrEn = psel && penable && pwrite;
  assign pready = 1'b1;
  always_comb
  begin
    case (paddr[7:2])
      msr_pkg::OFF_ERR_STATUS[7:2], msr_pkg::OFF_AXIS_STATUS[7:2], msr_pkg::OFF_SYS_STATUS[7:2],
      msr_pkg::OFF_OVERLAY[7:2], msr_pkg::OFF_TRAP_CLEAR[7:2], msr_pkg::OFF_POS_ERR_THR[7:2],
      msr_pkg::OFF_VEL_THR[7:2], msr_pkg::OFF_ACCEL_THR[7:2], msr_pkg::OFF_CUR_LEVEL[7:2],
      msr_pkg::OFF_CUR_TIMEOUT[7:2], msr_pkg::OFF_CAL_SIZE[7:2], msr_pkg::OFF_CONFIG[7:2]: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !mapped;

  // Parameter registers; status words have no write path
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      posErrThr_reg <= msr_pkg::THR_RESET;
      velThr_reg <= msr_pkg::THR_RESET;
      accelThr_reg <= msr_pkg::THR_RESET;
      curLevel_reg <= msr_pkg::CUR_LEVEL_RESET;
      curTimeout_reg <= msr_pkg::CUR_TIMEOUT_RESET;
      calSize_reg <= msr_pkg::CAL_SIZE_RESET;
      config_reg <= msr_pkg::CONFIG_RESET;
    end
    else if (wrEn)
    begin
      if (msrHit(paddr, msr_pkg::OFF_POS_ERR_THR))
        posErrThr_reg <= pwdata;
      if (msrHit(paddr, msr_pkg::OFF_VEL_THR))
        velThr_reg <= pwdata;
      if (msrHit(paddr, msr_pkg::OFF_ACCEL_THR))
        accelThr_reg <= pwdata;
      if (msrHit(paddr, msr_pkg::OFF_CUR_LEVEL))
        curLevel_reg <= pwdata[15:0];
      if (msrHit(paddr, msr_pkg::OFF_CUR_TIMEOUT))
        curTimeout_reg <= pwdata[15:0];
      if (msrHit(paddr, msr_pkg::OFF_CAL_SIZE))
        calSize_reg <= pwdata[15:0];
      if (msrHit(paddr, msr_pkg::OFF_CONFIG))
        config_reg <= pwdata[9:0];
    end
  end

  // Software traps latch; a set in the same cycle as a clear wins
  generate
    for (genvar i = 0; i < msr_pkg::SW_TRAP_COUNT; i++)
    begin : g_sw
      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst)
          swTrap_reg[i] <= 1'b0;
        else if (wrEn && msrHit(paddr, msr_pkg::OFF_OVERLAY) && pwdata[msr_pkg::ERR_SW_TRAP0 + i])
          swTrap_reg[i] <= 1'b1;
        else if (wrEn && msrHit(paddr, msr_pkg::OFF_TRAP_CLEAR) && pwdata[msr_pkg::ERR_SW_TRAP0 + i])
          swTrap_reg[i] <= 1'b0;
      end
    end
  endgenerate

  // Default trap actions
  assign stopTask1 = swTrap_reg[0] && taskRunning[0];
  assign stopTask2 = swTrap_reg[1] && taskRunning[1];
  assign ampDisable = swTrap_reg[2];

  // Mode and sticky state
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      absMode_reg <= 1'b1;
    else if (absolute_mode_cmd)
      absMode_reg <= 1'b1;
    else if (incremental_mode_cmd)
      absMode_reg <= 1'b0;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      hold_reg <= '0;
    else
      hold_reg <= ({hold_task_two_cmd, hold_task_one_cmd}) | (hold_reg & ~holdRelease);
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      homed_reg <= 1'b0;
    else if (homingStart)
      homed_reg <= 1'b1;
    else if (softReset)
      homed_reg <= 1'b0;
  end

  // Word assembly
  always_comb
  begin
    errWord_next = '0;
    errWord_next[msr_pkg::ERR_RESOLVER] = resolverFitted && (resolverTrackFault || resolverDisconnected);
    errWord_next[msr_pkg::ERR_POS_TRAP] = tr.posTrap;
    errWord_next[msr_pkg::ERR_VEL_TRAP] = tr.velTrap;
    errWord_next[msr_pkg::ERR_ACCEL_TRAP] = tr.accelTrap;
    errWord_next[msr_pkg::ERR_CUR_TRAP] = tr.curTrap;
    errWord_next[msr_pkg::ERR_SW_TRAP0 +: msr_pkg::SW_TRAP_COUNT] = swTrap_reg;
    errWord_next[msr_pkg::ERR_RUN_T1] = runTimeError[0];
    errWord_next[msr_pkg::ERR_RUN_T2] = runTimeError[1];
    errWord_next[msr_pkg::ERR_CAL_RANGE] = tr.calRange;
    axisWord_next = {homed_reg, disableMaskBusy, motionPresent, sixStepMode, holdCurrentHigh, velFbSource,
                     commutation, markerSource, posFbSource, curCmdNegated, 1'b0, integDisabled,
                     feedforwardOn};
    sysWord_next = '0;
    sysWord_next[0] = absMode_reg;
    sysWord_next[1] = kernelSync && (kSel == msr_pkg::KSYNC_ACTIVE);
    sysWord_next[3:2] = taskRunning;
    sysWord_next[5:4] = taskBlockMode;
    sysWord_next[7:6] = taskBlockExec;
    sysWord_next[9:8] = hold_reg;
    sysWord_next[10] = posCmdReference;
    sysWord_next[11] = resolver14Bit && (resMode == msr_pkg::RESMODE_DYNAMIC);
    sysWord_next[12] = (recirc == msr_pkg::RECIRC_ON) || (recirc == msr_pkg::RECIRC_ALWAYS);
    sysWord_next[13] = (recirc == msr_pkg::RECIRC_ALWAYS);
    sysWord_next[14] = gearActive;
    sysWord_next[15] = config_reg[msr_pkg::CFG_CAL_EN];
  end

  // Snapshot per update cycle so a read never mixes two cycles
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      errWord_reg <= '0;
      axisWord_reg <= '0;
      sysWord_reg <= '0;
    end
    else if (updateTick)
    begin
      errWord_reg <= errWord_next;
      axisWord_reg <= axisWord_next;
      sysWord_reg <= sysWord_next;
    end
  end

  // Read data captured in the setup phase, held through access
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      prdata <= '0;
    else if (setupPhase)
    begin
      if (pwrite || !mapped)
        prdata <= '0;
      else if (msrHit(paddr, msr_pkg::OFF_ERR_STATUS))
        prdata <= {8'h00, errWord_reg};
      else if (msrHit(paddr, msr_pkg::OFF_AXIS_STATUS))
        prdata <= {8'h00, axisWord_reg};
      else if (msrHit(paddr, msr_pkg::OFF_SYS_STATUS))
        prdata <= {8'h00, sysWord_reg};
      else if (msrHit(paddr, msr_pkg::OFF_POS_ERR_THR))
        prdata <= posErrThr_reg;
      else if (msrHit(paddr, msr_pkg::OFF_VEL_THR))
        prdata <= velThr_reg;
      else if (msrHit(paddr, msr_pkg::OFF_ACCEL_THR))
        prdata <= accelThr_reg;
      else if (msrHit(paddr, msr_pkg::OFF_CUR_LEVEL))
        prdata <= {16'h0000, curLevel_reg};
      else if (msrHit(paddr, msr_pkg::OFF_CUR_TIMEOUT))
        prdata <= {16'h0000, curTimeout_reg};
      else if (msrHit(paddr, msr_pkg::OFF_CAL_SIZE))
        prdata <= {16'h0000, calSize_reg};
      else if (msrHit(paddr, msr_pkg::OFF_CONFIG))
        prdata <= {22'h000000, config_reg};
      else
        prdata <= '0;
    end
  end

  // Checks
  chk_overlay_sets_trap: assert property (@(posedge clk_sys) disable iff (rst)
    wrEn && msrHit(paddr, msr_pkg::OFF_OVERLAY) && pwdata[16] |=> swTrap_reg[0])
    else $error("overlay write did not set trap 1");
  chk_trap_amp_off: assert property (@(posedge clk_sys) disable iff (rst)
    swTrap_reg[2] |-> ampDisable)
    else $error("trap 3 without amplifier disable");
  chk_err_reserved_zero: assert property (@(posedge clk_sys) disable iff (rst)
    errWord_reg[23:22] == 2'b00 && errWord_reg[10:0] == 11'h000)
    else $error("reserved error bits set");
  chk_words_hold_steady: assert property (@(posedge clk_sys) disable iff (rst)
    !$past(updateTick) |-> $stable(errWord_reg) && $stable(sysWord_reg))
    else $error("status word changed between update cycles");
  chk_tick_period: assert property (@(posedge clk_sys) disable iff (rst)
    updateTick |=> !updateTick [*8])
    else $error("update tick too frequent");
  chk_abs_mode_cmd: assert property (@(posedge clk_sys) disable iff (rst)
    incremental_mode_cmd && !absolute_mode_cmd |=> !absMode_reg)
    else $error("incremental command did not clear absolute mode");
  chk_ksync_gate: assert property (@(posedge clk_sys) disable iff (rst)
    updateTick && kSel != msr_pkg::KSYNC_ACTIVE |=> !sysWord_reg[1])
    else $error("kernel sync flag with select not 3");
  chk_hold_sticky: assert property (@(posedge clk_sys) disable iff (rst)
    hold_task_one_cmd |=> hold_reg[0])
    else $error("hold command not latched");
  chk_recirc_always: assert property (@(posedge clk_sys) disable iff (rst)
    sysWord_reg[13] |-> sysWord_reg[12])
    else $error("recirculation bit 13 without bit 12");
  chk_status_no_write: assert property (@(posedge clk_sys) disable iff (rst)
    wrEn && msrHit(paddr, msr_pkg::OFF_ERR_STATUS) && !updateTick |=> $stable(errWord_reg))
    else $error("error word took a write");
endmodule

/* File: common/msr_pkg.sv */
/*
  Constants for the motion status register bank: bus offsets, field
  positions, reset values and update timing.
  Assumes a 125 MHz system clock and a 32-bit APB register bus.
*/
package msr_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_ERR_STATUS = 8'h00;
  localparam logic [7:0] OFF_AXIS_STATUS = 8'h04;
  localparam logic [7:0] OFF_SYS_STATUS = 8'h08;
  localparam logic [7:0] OFF_OVERLAY = 8'h0c;
  localparam logic [7:0] OFF_TRAP_CLEAR = 8'h10;
  localparam logic [7:0] OFF_POS_ERR_THR = 8'h14;
  localparam logic [7:0] OFF_VEL_THR = 8'h18;
  localparam logic [7:0] OFF_ACCEL_THR = 8'h1c;
  localparam logic [7:0] OFF_CUR_LEVEL = 8'h20;
  localparam logic [7:0] OFF_CUR_TIMEOUT = 8'h24;
  localparam logic [7:0] OFF_CAL_SIZE = 8'h28;
  localparam logic [7:0] OFF_CONFIG = 8'h2c;

  // Error word bits
  localparam int ERR_RESOLVER = 11;
  localparam int ERR_POS_TRAP = 12;
  localparam int ERR_VEL_TRAP = 13;
  localparam int ERR_ACCEL_TRAP = 14;
  localparam int ERR_CUR_TRAP = 15;
  localparam int ERR_SW_TRAP0 = 16;
  localparam int SW_TRAP_COUNT = 3;
  localparam int ERR_RUN_T1 = 19;
  localparam int ERR_RUN_T2 = 20;
  localparam int ERR_CAL_RANGE = 21;

  // Configuration register fields
  localparam int CFG_CAL_EN = 0;
  localparam int CFG_KSYNC_LSB = 2;
  localparam int CFG_RESMODE_LSB = 4;
  localparam int CFG_RECIRC_LSB = 8;
  localparam logic [1:0] KSYNC_ACTIVE = 2'h3;
  localparam logic [3:0] RESMODE_DYNAMIC = 4'h4;
  localparam logic [1:0] RECIRC_ON = 2'h1;
  localparam logic [1:0] RECIRC_ALWAYS = 2'h2;

  // Reset values
  localparam logic [31:0] THR_RESET = 32'h7fffffff;
  localparam logic [15:0] CUR_LEVEL_RESET = 16'h7fff;
  localparam logic [15:0] CUR_TIMEOUT_RESET = 16'h00ff;
  localparam logic [15:0] CAL_SIZE_RESET = 16'h0000;
  localparam logic [9:0] CONFIG_RESET = 10'h040;

  // Calibration position ceiling, steps
  localparam logic signed [31:0] CAL_POS_MAX = 32'sd16000000;

  // Controller update cycle
  localparam int CLK_PERIOD_NS = 8;
  localparam int UPDATE_PERIOD_NS = 1000;
  localparam int UPDATE_CYCLES = UPDATE_PERIOD_NS / CLK_PERIOD_NS;
endpackage

/* File: common/msr_trap_if.sv */
/*
  Carrier between the register bank and its trap evaluator.
  Assumes both ends run on clk_sys.
*/
`timescale 1ns/10ps
interface msr_trap_if;
  logic updateTick;
  logic signed [31:0] cmdPos;
  logic signed [31:0] fbPos;
  logic signed [31:0] fbVel;
  logic signed [15:0] curCmd;
  logic [31:0] posErrThr;
  logic [31:0] velThr;
  logic [31:0] accelThr;
  logic [15:0] curLevel;
  logic [15:0] curTimeout;
  logic calEnable;
  logic [15:0] calIndex;
  logic [15:0] calSize;
  logic posTrap;
  logic velTrap;
  logic accelTrap;
  logic curTrap;
  logic calRange;

  modport eval (
    input updateTick, cmdPos, fbPos, fbVel, curCmd, posErrThr, velThr, accelThr,
    input curLevel, curTimeout, calEnable, calIndex, calSize,
    output posTrap, velTrap, accelTrap, curTrap, calRange
  );
  modport bank (
    output updateTick, cmdPos, fbPos, fbVel, curCmd, posErrThr, velThr, accelThr,
    output curLevel, curTimeout, calEnable, calIndex, calSize,
    input posTrap, velTrap, accelTrap, curTrap, calRange
  );
endinterface

/* File: rtl/msr_trap_eval.sv */
/*
  Trap evaluator: position, velocity, accel, current-limit timeout and
  calibration range checks, refreshed once per update tick.
  Assumes inputs from logic on clk_sys; thresholds are magnitudes.
*/
`timescale 1ns/10ps
module msr_trap_eval (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Bank side
  msr_trap_if.eval tr
);
  function automatic logic [31:0] msrMag(input logic signed [31:0] v);
    msrMag = v[31] ? 32'(-v) : 32'(v);
  endfunction

  logic signed [31:0] prevPos_reg;
  logic signed [31:0] prevVel_reg;
  logic signed [31:0] derivVel;
  logic signed [31:0] derivAcc;
  logic [15:0] limitCount_reg;
  logic atLimit;

  assign derivVel = tr.fbPos - prevPos_reg;
  assign derivAcc = derivVel - prevVel_reg;
  assign atLimit = msrMag(32'(tr.curCmd)) >= {16'h0000, tr.curLevel};

  // Derivatives taken across one update period
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      prevPos_reg <= '0;
      prevVel_reg <= '0;
    end
    else if (tr.updateTick)
    begin
      prevPos_reg <= tr.fbPos;
      prevVel_reg <= derivVel;
    end
  end

  // Counts update cycles spent at the limit
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      limitCount_reg <= '0;
    else if (tr.updateTick)
      limitCount_reg <= !atLimit ? 16'h0000 : (&limitCount_reg ? limitCount_reg : limitCount_reg + 16'h0001);
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      tr.posTrap <= 1'b0;
      tr.velTrap <= 1'b0;
      tr.accelTrap <= 1'b0;
      tr.curTrap <= 1'b0;
      tr.calRange <= 1'b0;
    end
    else if (tr.updateTick)
    begin
      tr.posTrap <= msrMag(tr.cmdPos - tr.fbPos) > tr.posErrThr;
      tr.velTrap <= msrMag(tr.fbVel) > tr.velThr;
      tr.accelTrap <= msrMag(derivAcc) > tr.accelThr;
      tr.curTrap <= atLimit && (limitCount_reg >= tr.curTimeout);
      tr.calRange <= tr.calEnable && (tr.fbPos < 0 || tr.fbPos > msr_pkg::CAL_POS_MAX
                     || tr.calIndex > tr.calSize);
    end
  end
endmodule

/* File: verif/tb_top.sv */
/*
  Self-checking bench for the motion status register bank over APB.
  Assumes pready is always high and the words refresh every update tick.
*/
`timescale 1ns/10ps
module tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = '0, penable = '0, pwrite = '0, se, pready, pslverr;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic stopTask1, stopTask2, ampDisable;
  logic signed [31:0] cmdPos = '0, fbPos = '0, fbVel = '0;
  logic signed [15:0] curCmd = '0;
  logic [15:0] calIndex = '0;
  logic resolverFitted = '0, resolverTrackFault = '0, resolverDisconnected = '0;
  logic [1:0] runTimeError = '0, sixStepMode = '0, markerSource = '0;
  logic [3:0] posFbSource = '0, velFbSource = '0, commutation = '0;
  logic feedforwardOn = '0, integDisabled = '0, curCmdNegated = '0, holdCurrentHigh = '0;
  logic motionPresent = '0, disableMaskBusy = '0, homingStart = '0, softReset = '0;
  logic absolute_mode_cmd = '0, incremental_mode_cmd = '0, kernelSync = '0;
  logic [1:0] taskRunning = '0, taskBlockMode = '0, taskBlockExec = '0, holdRelease = '0;
  logic hold_task_one_cmd = '0, hold_task_two_cmd = '0;
  logic posCmdReference = '0, resolver14Bit = '0, gearActive = '0;
  int errCount = 0;
  int checked = 0;

  always #4 clk_sys = ~clk_sys;

  msr_status_bank dut_u (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .cmdPos, .fbPos, .fbVel, .curCmd, .calIndex, .resolverFitted, .resolverTrackFault,
    .resolverDisconnected, .runTimeError, .posFbSource, .velFbSource, .commutation, .sixStepMode,
    .markerSource, .feedforwardOn, .integDisabled, .curCmdNegated, .holdCurrentHigh, .motionPresent,
    .disableMaskBusy, .homingStart, .softReset, .absolute_mode_cmd, .incremental_mode_cmd, .kernelSync,
    .taskRunning, .taskBlockMode, .taskBlockExec, .hold_task_one_cmd, .hold_task_two_cmd, .holdRelease,
    .posCmdReference, .resolver14Bit, .gearActive, .stopTask1, .stopTask2, .ampDisable);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errCount++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Idle cycle after each transfer keeps psel from being assigned twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // No local limit: a slave that never answers is left to the watchdog
    do
    begin
      @(posedge clk_sys);
    end
    while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic ticks(input int n);
    repeat (n * msr_pkg::UPDATE_CYCLES) @(posedge clk_sys);
  endtask

  task automatic t_reset();
    rchk(8'h14, msr_pkg::THR_RESET);
    rchk(8'h24, {16'h0, msr_pkg::CUR_TIMEOUT_RESET});
    rchk(8'h2c, {22'h0, msr_pkg::CONFIG_RESET});
    rchk(8'h0c, 32'h0);
    rchk(8'h30, 32'h0);
    chk({31'h0, se}, 32'h1);
    $display("test reset done");
  endtask

  task automatic t_axis();
    {posFbSource, velFbSource, commutation, sixStepMode, markerSource} <= {4'h2, 4'h8, 4'h4, 2'h1, 2'h2};
    {feedforwardOn, integDisabled, curCmdNegated, holdCurrentHigh, motionPresent, disableMaskBusy} <= 6'h2d;
    homingStart <= 1'b1;
    @(posedge clk_sys);
    homingStart <= 1'b0;
    ticks(2);
    apb(1'b1, 8'h04, 32'hffffffff);
    rchk(8'h04, 32'h00ce1229);
    {feedforwardOn, integDisabled, curCmdNegated, holdCurrentHigh, motionPresent, disableMaskBusy} <= 6'h12;
    softReset <= 1'b1;
    @(posedge clk_sys);
    softReset <= 1'b0;
    ticks(2);
    rchk(8'h04, 32'h002a1222);
    $display("test axis done");
  endtask

  task automatic t_sys();
    apb(1'b1, 8'h2c, 32'h24d);
    {kernelSync, posCmdReference, resolver14Bit, gearActive} <= 4'hf;
    {taskRunning, taskBlockMode, taskBlockExec} <= 6'h1a;
    {hold_task_two_cmd, incremental_mode_cmd} <= 2'h3;
    @(posedge clk_sys);
    {hold_task_two_cmd, incremental_mode_cmd} <= 2'h0;
    ticks(2);
    rchk(8'h08, {16'h0, 4'hf, 2'h3, 2'h2, taskBlockExec, taskBlockMode, taskRunning, 2'h2});
    // Selects off: sync, narrow tracking and stay-on recirculation must drop
    apb(1'b1, 8'h2c, 32'h100);
    {holdRelease, absolute_mode_cmd} <= 3'h5;
    @(posedge clk_sys);
    {holdRelease, absolute_mode_cmd} <= 3'h0;
    ticks(2);
    rchk(8'h08, {16'h0, 4'h5, 2'h1, 2'h0, taskBlockExec, taskBlockMode, taskRunning, 2'h1});
    $display("test system done");
  endtask

  task automatic t_err();
    apb(1'b1, 8'h14, 32'h64);
    cmdPos <= 32'sh000000c8;
    fbPos <= 32'sh00000032;
    runTimeError <= 2'h3;
    {resolverFitted, resolverTrackFault} <= 2'h3;
    apb(1'b1, 8'h0c, 32'h00070000);
    ticks(3);
    rchk(8'h00, 32'h001f1800);
    chk({29'h0, stopTask1, stopTask2, ampDisable}, 32'h5);
    apb(1'b1, 8'h10, 32'h00070000);
    apb(1'b1, 8'h14, msr_pkg::THR_RESET);
    apb(1'b1, 8'h18, 32'hc8);
    apb(1'b1, 8'h2c, 32'h141);
    apb(1'b1, 8'h0c, 32'h00f80000);
    apb(1'b1, 8'h00, 32'hffffffff);
    runTimeError <= 2'h0;
    resolverFitted <= 1'b0;
    fbVel <= -32'sh0000012c;
    cmdPos <= -32'sh00000005;
    fbPos <= -32'sh00000005;
    ticks(3);
    rchk(8'h00, 32'h00202000);
    chk({29'h0, stopTask1, stopTask2, ampDisable}, 32'h0);
    $display("test error done");
  endtask

  // Position step gives an accel spike for two ticks; current held at limit past a 2-tick timeout
  task automatic t_trap();
    apb(1'b1, 8'h1c, 32'h10);
    apb(1'b1, 8'h20, 32'h100);
    apb(1'b1, 8'h24, 32'h2);
    fbVel <= '0;
    cmdPos <= 32'sh00000100;
    fbPos <= 32'sh00000100;
    curCmd <= -16'sh0100;
    calIndex <= 16'h0001;
    ticks(2);
    rchk(8'h00, 32'h00204000);
    ticks(3);
    rchk(8'h00, 32'h00208000);
    $display("test trap done");
  endtask

  task automatic print_verdict();
    $display("checked=%0d errCount=%0d", checked, errCount);
    if (errCount == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_axis();
    t_sys();
    t_err();
    t_trap();
    print_verdict();
  end

  // Tests need about 2500 cycles; far beyond that means a hang
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    errCount++;
    print_verdict();
  end
endmodule
